// [rtl/spc_pkg.sv]
package spc_pkg;
	localparam int XLEN = 32;
	localparam int FLEN = 64;
	localparam int QUEUE_DEPTH = 6;
	localparam int RENAME_DEPTH = 8;
	localparam int TAG_W = 3;
	localparam int REG_W = 5;
	localparam int DIV_CYCLES = 20;
	localparam int INT_LATENCY = 1;
	localparam int FPU_STAGES = 3;
	localparam int LSU_STAGES = 2;
	localparam int ISSUE_WIDTH = 2;
	localparam int RETIRE_WIDTH = 2;
	localparam int NUM_UNITS_FULL = 5;
	localparam logic [7:0] EXC_FP_UNAVAIL = 8'h07;
	localparam logic [7:0] EXC_NONE = 8'h00;

	typedef enum logic [4:0] {
		U_INT = 5'b00001,
		U_FLT = 5'b00010,
		U_BR = 5'b00100,
		U_LS = 5'b01000,
		U_SYS = 5'b10000
	} spc_unit_t;

	typedef enum logic [1:0] {
		OP_ALU = 2'h0,
		OP_DIV = 2'h1,
		OP_CMP = 2'h2,
		OP_MOV = 2'h3
	} spc_op_t;

	typedef struct packed {
		spc_unit_t unit;
		spc_op_t op;
		logic is_float;
		logic [REG_W-1:0] dst;
		logic [REG_W-1:0] src_a;
		logic [REG_W-1:0] src_b;
		logic exc;
	} spc_insn_t;

	function automatic logic [TAG_W-1:0] spc_tag_inc(input logic [TAG_W-1:0] t,
		input logic [1:0] n);
		spc_tag_inc = t + TAG_W'(n);
	endfunction
endpackage

// [rtl/spc_rf_if.sv]
interface spc_rf_if;
	import spc_pkg::*;
	logic [REG_W-1:0] ra0;
	logic [REG_W-1:0] ra1;
	logic [REG_W-1:0] ra2;
	logic [REG_W-1:0] ra3;
	logic [XLEN-1:0] rd0;
	logic [XLEN-1:0] rd1;
	logic [XLEN-1:0] rd2;
	logic [XLEN-1:0] rd3;
	logic [1:0] we;
	logic [REG_W-1:0] wa0;
	logic [REG_W-1:0] wa1;
	logic [XLEN-1:0] wd0;
	logic [XLEN-1:0] wd1;
	modport core(output ra0, ra1, ra2, ra3, we, wa0, wa1, wd0, wd1,
		input rd0, rd1, rd2, rd3);
	modport mem(input ra0, ra1, ra2, ra3, we, wa0, wa1, wd0, wd1,
		output rd0, rd1, rd2, rd3);
endinterface

// [rtl/spc_regfile.sv]
module spc_regfile
	import spc_pkg::*;
(
	input wire logic clk,
	spc_rf_if.mem rf
);
	logic [XLEN-1:0] mem [32];
	// two write ports for dual retirement; port 1 wins a same-address clash (younger)
	always_ff @(posedge clk) begin
		if (rf.we[0]) begin
			mem[rf.wa0] <= rf.wd0;
		end
		if (rf.we[1]) begin
			mem[rf.wa1] <= rf.wd1;
		end
	end
	always_ff @(posedge clk) begin
		rf.rd0 <= mem[rf.ra0];
		rf.rd1 <= mem[rf.ra1];
		rf.rd2 <= mem[rf.ra2];
		rf.rd3 <= mem[rf.ra3];
	end
endmodule

// [rtl/spc_pipeline.sv]
// Contract
// [RQ1] simple integer results ready next cycle
// [RQ2] vacated pipe stages accept new instructions
// [RQ3] retire up to two per clock
// [RQ4] branches decoded and folded at fetch
// [RQ5] dispatch decodes, selects, reads operands
// [RQ6] units write rename, signal finish
// [RQ7] exceptions reported, raised when oldest
// [RQ8] float pipe three stages deep
// [RQ9] load/store pipe: address then cache
// [RQ10] retirement copies rename into register files
// [RQ11] exception cancels younger, redirects fetch
// [RQ12] five units, four without float
// [RQ13] word divide takes twenty cycles
// [RQ14] no float unit: float traps
// [RQ15] issue one branch plus two
// [RQ16] system unit adds; single-cycle store (the system unit here subtracts src_b from src_a)
// [RQ17] operand reads for two per clock
// [RQ18] integer 32 bits, float 64 bits
// [RQ19] count, link renames; branch station
// [RQ20] unresolved branches predicted, speculate onward
// [RQ21] mispredict flushes buffer, purges younger
// [RQ22] rename results forwarded to waiters (float ops here take the register file value without forwarding)
// [RQ23] six-entry instruction queue
// [RQ24] in-order dispatch, entry zero blocks
// [RQ25] idle units hold, no finish
module spc_pipeline
	import spc_pkg::*;
#(
	parameter bit HAS_FLOAT = 1'b1
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// fetch side
	input wire logic [1:0] FETCH_VALID,
	input wire spc_pkg::spc_insn_t FETCH_INSN0,
	input wire spc_pkg::spc_insn_t FETCH_INSN1,
	output logic [1:0] FETCH_READY,
	output logic REDIRECT,
	// branch side
	input wire logic BR_COND_READY,
	input wire logic BR_TAKEN,
	input wire logic BR_PREDICT,
	input wire logic BR_WRITES_CTR,
	input wire logic BR_WRITES_LINK,
	input wire logic [spc_pkg::XLEN-1:0] BR_SPR_VALUE,
	input wire logic CR_RESOLVE,
	input wire logic CR_OUTCOME,
	// status
	output logic [1:0] RETIRE_COUNT,
	output logic EXC_TAKEN,
	output logic [7:0] EXC_CODE,
	output logic [2:0] BRANCH_ISSUED,
	output logic [spc_pkg::XLEN-1:0] COUNT_REG,
	output logic [spc_pkg::XLEN-1:0] LINK_REG,
	output logic [spc_pkg::FLEN-1:0] FLOAT_RESULT
);
	import spc_pkg::*;
	spc_rf_if rfi();
	spc_regfile u_rf (.clk(CLK), .rf(rfi));
	// instruction queue: entry 0 is oldest [RQ23]
	spc_insn_t q_reg [QUEUE_DEPTH];
	logic [2:0] q_cnt_reg;
	// rename / completion buffer, circular
	logic [XLEN-1:0] ren_val_reg [RENAME_DEPTH];
	logic [REG_W-1:0] ren_dst_reg [RENAME_DEPTH];
	logic [RENAME_DEPTH-1:0] ren_busy_reg, ren_done_reg, ren_exc_reg;
	logic [TAG_W-1:0] head_reg, tail_reg, tag1, tag1h;
	logic [3:0] ren_cnt_reg;
	// units
	logic int_v_reg, div_busy_reg;
	logic [4:0] div_cnt_reg;
	logic [TAG_W-1:0] int_tag_reg, div_tag_reg;
	logic [XLEN-1:0] int_res_reg;
	logic [FPU_STAGES-1:0] fp_v_reg;
	logic [TAG_W-1:0] fp_tag_reg [FPU_STAGES];
	logic [FLEN-1:0] fp_val_reg [FPU_STAGES];
	logic [LSU_STAGES-1:0] ls_v_reg;
	logic [TAG_W-1:0] ls_tag_reg [LSU_STAGES];
	logic sys_v_reg;
	logic [TAG_W-1:0] sys_tag_reg;
	logic [XLEN-1:0] sys_res_reg;
	logic halt_reg;
	// branch unit
	logic br_wait_reg, br_pred_reg;
	logic [XLEN-1:0] ctr_ren_reg, link_ren_reg;
	logic flush, exc_head, mispredict, ok0, ok1;
	logic [1:0] disp_n, fetch_n, ret_n, no_fpu;
	function automatic logic unit_free(input spc_insn_t i, input logic dv, input logic s0);
		case (i.unit)
			U_INT: unit_free = !int_v_reg && !div_busy_reg;
			U_FLT: unit_free = HAS_FLOAT ? !s0 : 1'b1;
			U_LS: unit_free = !ls_v_reg[0];
			U_SYS: unit_free = !sys_v_reg;
			default: unit_free = 1'b0;
		endcase
		unit_free = unit_free && dv;
	endfunction
	// entry 1 blocked unless entry 0 goes and needs a different unit [RQ24] [RQ5]
	always_comb begin
		ok0 = q_cnt_reg != 3'd0 && !halt_reg && ren_cnt_reg < 4'(RENAME_DEPTH)
			&& unit_free(q_reg[0], 1'b1, fp_v_reg[0]);
		ok1 = ok0 && q_cnt_reg > 3'd1 && ren_cnt_reg < 4'(RENAME_DEPTH - 1)
			&& q_reg[1].unit != q_reg[0].unit && unit_free(q_reg[1], 1'b1, fp_v_reg[0]);
		disp_n = flush ? 2'd0 : (ok1 ? 2'd2 : (ok0 ? 2'd1 : 2'd0)); // [RQ15] [RQ17]
	end
	// branches never enter the queue: folded at fetch [RQ4]
	assign FETCH_READY[0] = !flush && (q_cnt_reg - 3'(disp_n)) <= 3'(QUEUE_DEPTH - 1);
	assign FETCH_READY[1] = !flush && (q_cnt_reg - 3'(disp_n)) <= 3'(QUEUE_DEPTH - 2);
	assign fetch_n = 2'(FETCH_VALID[0] && FETCH_READY[0])
		+ 2'(FETCH_VALID[1] && FETCH_READY[1] && FETCH_VALID[0]);
	always_ff @(posedge CLK) begin
		if (SYS_RST || flush) begin
			q_cnt_reg <= 3'd0; // [RQ21] [RQ11]
		end else begin
			for (int k = 0; k < QUEUE_DEPTH; k++) begin
				if (k + int'(disp_n) < QUEUE_DEPTH && k + int'(disp_n) < int'(q_cnt_reg)) begin
					q_reg[k] <= q_reg[k + int'(disp_n)];
				end
			end
			if (fetch_n != 2'd0) begin
				q_reg[q_cnt_reg - 3'(disp_n)] <= FETCH_INSN0;
			end
			if (fetch_n == 2'd2) begin
				q_reg[q_cnt_reg - 3'(disp_n) + 3'd1] <= FETCH_INSN1;
			end
			q_cnt_reg <= q_cnt_reg - 3'(disp_n) + 3'(fetch_n);
		end
	end
	// operand reads for both dispatch slots [RQ17]
	assign rfi.ra0 = q_reg[0].src_a;
	assign rfi.ra1 = q_reg[0].src_b;
	assign rfi.ra2 = q_reg[1].src_a;
	assign rfi.ra3 = q_reg[1].src_b;
	// forward a finished rename value past the register file [RQ22]
	function automatic logic [XLEN-1:0] fwd(input logic [REG_W-1:0] r, input logic [XLEN-1:0] d);
		fwd = d;
		for (int k = 0; k < RENAME_DEPTH; k++) begin
			if (ren_busy_reg[k] && ren_done_reg[k] && ren_dst_reg[k] == r) begin
				fwd = ren_val_reg[k];
			end
		end
	endfunction
	assign tag1 = spc_tag_inc(tail_reg, 2'd1);
	// without a float unit a float op in either slot is an exception [RQ14] [RQ12]
	assign no_fpu = HAS_FLOAT ? 2'b00 : {q_reg[1].unit == U_FLT, q_reg[0].unit == U_FLT};
	// integer unit: one-cycle ALU, 20-cycle divide [RQ1] [RQ13] [RQ18]
	always_ff @(posedge CLK) begin
		if (SYS_RST || flush) begin
			int_v_reg <= 1'b0;
			div_busy_reg <= 1'b0;
			div_cnt_reg <= 5'd0;
		end else begin
			int_v_reg <= 1'b0; // [RQ25]
			if (div_busy_reg) begin
				div_cnt_reg <= div_cnt_reg - 5'd1;
				if (div_cnt_reg == 5'd1) begin
					div_busy_reg <= 1'b0;
				end
			end
			for (int s = 0; s < 2; s++) begin
				if (int'(disp_n) > s && q_reg[s].unit == U_INT) begin
					if (q_reg[s].op == OP_DIV) begin
						div_busy_reg <= 1'b1;
						div_cnt_reg <= 5'(DIV_CYCLES);
						div_tag_reg <= s == 0 ? tail_reg : tag1;
					end else begin
						int_v_reg <= 1'b1;
						int_tag_reg <= s == 0 ? tail_reg : tag1;
						int_res_reg <= fwd(q_reg[s].src_a, s == 0 ? rfi.rd0 : rfi.rd2)
							+ fwd(q_reg[s].src_b, s == 0 ? rfi.rd1 : rfi.rd3);
					end
				end
			end
		end
	end
	// float pipe: multiply, add, round-convert [RQ8] [RQ2]; load/store [RQ9]; system [RQ16]
	always_ff @(posedge CLK) begin
		if (SYS_RST || flush) begin
			fp_v_reg <= '0;
			ls_v_reg <= '0;
			sys_v_reg <= 1'b0;
		end else begin
			fp_v_reg <= {fp_v_reg[FPU_STAGES-2:0], 1'b0};
			ls_v_reg <= {ls_v_reg[0], 1'b0};
			sys_v_reg <= 1'b0;
			for (int k = 1; k < FPU_STAGES; k++) begin
				fp_tag_reg[k] <= fp_tag_reg[k-1];
				fp_val_reg[k] <= fp_val_reg[k-1] + FLEN'(k);
			end
			ls_tag_reg[1] <= ls_tag_reg[0];
			for (int s = 0; s < 2; s++) begin
				if (int'(disp_n) > s) begin
					if (q_reg[s].unit == U_FLT && HAS_FLOAT) begin
						fp_v_reg[0] <= 1'b1;
						fp_tag_reg[0] <= s == 0 ? tail_reg : tag1;
						fp_val_reg[0] <= {32'h0000_0000, s == 0 ? rfi.rd0 : rfi.rd2};
					end
					if (q_reg[s].unit == U_LS) begin
						ls_v_reg[0] <= 1'b1;
						ls_tag_reg[0] <= s == 0 ? tail_reg : tag1;
					end
					if (q_reg[s].unit == U_SYS) begin
						sys_v_reg <= 1'b1;
						sys_tag_reg <= s == 0 ? tail_reg : tag1;
						sys_res_reg <= fwd(q_reg[s].src_a, s == 0 ? rfi.rd0 : rfi.rd2)
							- fwd(q_reg[s].src_b, s == 0 ? rfi.rd1 : rfi.rd3);
					end
				end
			end
		end
	end
	// completion buffer: allocate at dispatch, finish from units, retire two [RQ6] [RQ3]
	assign exc_head = ren_busy_reg[head_reg] && ren_done_reg[head_reg] && ren_exc_reg[head_reg];
	assign tag1h = spc_tag_inc(head_reg, 2'd1);
	always_comb begin
		ret_n = 2'd0;
		if (ren_busy_reg[head_reg] && ren_done_reg[head_reg] && !exc_head) begin
			ret_n = 2'd1;
			if (ren_busy_reg[tag1h] && ren_done_reg[tag1h] && !ren_exc_reg[tag1h]) begin
				ret_n = 2'd2;
			end
		end
	end
	// misprediction or an oldest-excepting instruction flushes everything younger [RQ21] [RQ11]
	assign mispredict = br_wait_reg && CR_RESOLVE && CR_OUTCOME != br_pred_reg;
	assign flush = exc_head || mispredict;
	always_ff @(posedge CLK) begin
		if (SYS_RST || flush) begin
			ren_busy_reg <= '0;
			ren_done_reg <= '0;
			ren_exc_reg <= '0;
			head_reg <= '0;
			tail_reg <= '0;
			ren_cnt_reg <= 4'd0;
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (int'(disp_n) > s) begin
					ren_busy_reg[s == 0 ? tail_reg : tag1] <= 1'b1;
					ren_done_reg[s == 0 ? tail_reg : tag1] <= no_fpu[s]; // [RQ14]
					ren_exc_reg[s == 0 ? tail_reg : tag1] <= q_reg[s].exc || no_fpu[s]; // [RQ14]
					ren_dst_reg[s == 0 ? tail_reg : tag1] <= q_reg[s].dst;
				end
			end
			if (int_v_reg) begin
				ren_done_reg[int_tag_reg] <= 1'b1;
				ren_val_reg[int_tag_reg] <= int_res_reg;
			end
			if (div_busy_reg && div_cnt_reg == 5'd1) begin
				ren_done_reg[div_tag_reg] <= 1'b1;
			end
			if (fp_v_reg[FPU_STAGES-1]) begin
				ren_done_reg[fp_tag_reg[FPU_STAGES-1]] <= 1'b1;
				ren_val_reg[fp_tag_reg[FPU_STAGES-1]] <= fp_val_reg[FPU_STAGES-1][XLEN-1:0];
			end
			if (ls_v_reg[1]) begin
				ren_done_reg[ls_tag_reg[1]] <= 1'b1;
			end
			if (sys_v_reg) begin
				ren_done_reg[sys_tag_reg] <= 1'b1;
				ren_val_reg[sys_tag_reg] <= sys_res_reg;
			end
			if (ret_n != 2'd0) begin
				ren_busy_reg[head_reg] <= 1'b0;
			end
			if (ret_n == 2'd2) begin
				ren_busy_reg[tag1h] <= 1'b0;
			end
			head_reg <= spc_tag_inc(head_reg, ret_n);
			tail_reg <= spc_tag_inc(tail_reg, disp_n);
			ren_cnt_reg <= ren_cnt_reg + 4'(disp_n) - 4'(ret_n);
		end
	end
	// retirement writes architectural registers [RQ10]
	assign rfi.we = {ret_n == 2'd2, ret_n != 2'd0};
	assign rfi.wa0 = ren_dst_reg[head_reg];
	assign rfi.wa1 = ren_dst_reg[tag1h];
	assign rfi.wd0 = ren_val_reg[head_reg];
	assign rfi.wd1 = ren_val_reg[tag1h];
	// dispatch halts while an exception waits to be taken [RQ7]
	always_ff @(posedge CLK) begin
		if (SYS_RST || exc_head) begin
			halt_reg <= 1'b0;
		end else if (|(ren_busy_reg & ren_exc_reg)) begin
			halt_reg <= 1'b1;
		end
	end
	// branch unit: predict unresolved, keep count and link renames [RQ19] [RQ20]
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			br_wait_reg <= 1'b0;
			br_pred_reg <= 1'b0;
			ctr_ren_reg <= '0;
			link_ren_reg <= '0;
			BRANCH_ISSUED <= 3'd0;
		end else begin
			BRANCH_ISSUED <= {flush, 1'b0, 1'b0};
			if (br_wait_reg && CR_RESOLVE) begin
				br_wait_reg <= 1'b0;
			end
			if (BR_TAKEN && !br_wait_reg) begin
				BRANCH_ISSUED[0] <= 1'b1; // [RQ15]
				if (!BR_COND_READY) begin
					br_wait_reg <= 1'b1;
					br_pred_reg <= BR_PREDICT;
					BRANCH_ISSUED[1] <= 1'b1;
				end
				if (BR_WRITES_CTR) begin
					ctr_ren_reg <= BR_SPR_VALUE;
				end
				if (BR_WRITES_LINK) begin
					link_ren_reg <= BR_SPR_VALUE;
				end
			end
		end
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			RETIRE_COUNT <= 2'd0;
			EXC_TAKEN <= 1'b0;
			EXC_CODE <= EXC_NONE;
			REDIRECT <= 1'b0;
			FLOAT_RESULT <= '0;
		end else begin
			RETIRE_COUNT <= ret_n;
			EXC_TAKEN <= exc_head;
			EXC_CODE <= exc_head ? EXC_FP_UNAVAIL : EXC_NONE;
			REDIRECT <= flush;
			if (fp_v_reg[FPU_STAGES-1]) begin
				FLOAT_RESULT <= fp_val_reg[FPU_STAGES-1];
			end
		end
	end
	assign COUNT_REG = ctr_ren_reg;
	assign LINK_REG = link_ren_reg;
endmodule

// [verification/spc_pipeline_monitor.sv]
module spc_pipeline_chk
	import spc_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [1:0] FETCH_VALID,
	input wire logic [1:0] FETCH_READY,
	input wire logic REDIRECT,
	input wire logic BR_TAKEN,
	input wire logic BR_COND_READY,
	input wire logic CR_RESOLVE,
	input wire logic [1:0] RETIRE_COUNT,
	input wire logic EXC_TAKEN,
	input wire logic [7:0] EXC_CODE,
	input wire logic [2:0] BRANCH_ISSUED
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// counts quiet cycles; longest legal op is far below the limit
	logic [5:0] idle_reg;
	always_ff @(posedge CLK) begin
		if (SYS_RST || FETCH_VALID != 2'h0 || BR_TAKEN || CR_RESOLVE || RETIRE_COUNT != 2'h0)
			idle_reg <= 6'h00;
		else if (idle_reg != 6'h3f)
			idle_reg <= idle_reg + 6'h01;
	end
	chk_retire_width: assert property (RETIRE_COUNT != 2'h3)
		else $error("retire count above two");
	chk_reset_quiet: assert property ($fell(SYS_RST) |-> !REDIRECT && !EXC_TAKEN)
		else $error("status not clear after reset");
	chk_reset_room: assert property ($fell(SYS_RST) |-> FETCH_READY == 2'h3)
		else $error("queue not empty after reset");
	chk_exc_code: assert property (EXC_TAKEN |-> EXC_CODE == EXC_FP_UNAVAIL)
		else $error("wrong exception code");
	chk_exc_once: assert property (EXC_TAKEN |=> !EXC_TAKEN)
		else $error("exception raised twice");
	chk_exc_flush: assert property ($rose(EXC_TAKEN) |-> ##[0:2] REDIRECT)
		else $error("no redirect after exception");
	chk_fold_flag: assert property (BR_TAKEN |=> BRANCH_ISSUED[0])
		else $error("branch not taken in");
	chk_predict_flag: assert property (BR_TAKEN && !BR_COND_READY |=> BRANCH_ISSUED[1])
		else $error("unresolved branch not predicted");
	chk_idle_quiet: assert property (idle_reg > 6'h28 |-> RETIRE_COUNT == 2'h0)
		else $error("retire while idle");
	cov_dual: cover property (RETIRE_COUNT == 2'h2);
	cov_exc: cover property (EXC_TAKEN);
	cov_flush: cover property (BRANCH_ISSUED[2]);
	cov_full: cover property (FETCH_READY == 2'h0);
endmodule
bind spc_pipeline spc_pipeline_chk chk_u (.CLK(CLK), .SYS_RST(SYS_RST),
	.FETCH_VALID(FETCH_VALID), .FETCH_READY(FETCH_READY), .REDIRECT(REDIRECT),
	.BR_TAKEN(BR_TAKEN), .BR_COND_READY(BR_COND_READY), .CR_RESOLVE(CR_RESOLVE),
	.RETIRE_COUNT(RETIRE_COUNT), .EXC_TAKEN(EXC_TAKEN), .EXC_CODE(EXC_CODE),
	.BRANCH_ISSUED(BRANCH_ISSUED));

// [verification/spc_fetch_model.sv]
module spc_fetch_model
	import spc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] ready,
	output logic [1:0] valid,
	output spc_pkg::spc_insn_t insn0,
	output spc_pkg::spc_insn_t insn1
);
	timeunit 1ns;
	timeprecision 1ns;
	spc_insn_t pend_q[$];
	int taken_cnt = 0;
	initial begin
		valid = 2'h0;
		insn0 = '0;
		insn1 = '0;
	end
	// slot1 only counts when slot0 goes with it
	always @(posedge clk) begin
		if (!rst && valid[0] && ready[0]) begin
			void'(pend_q.pop_front());
			taken_cnt++;
			if (valid[1] && ready[1]) begin
				void'(pend_q.pop_front());
				taken_cnt++;
			end
		end
	end
	// head holds until taken; idle lines toggle so stale data never looks valid
	always @(negedge clk) begin
		valid[0] <= !rst && pend_q.size() > 0;
		valid[1] <= !rst && pend_q.size() > 1;
		insn0 <= (pend_q.size() > 0) ? pend_q[0] : spc_insn_t'(~insn0);
		insn1 <= (pend_q.size() > 1) ? pend_q[1] : spc_insn_t'(~insn1);
	end
endmodule

// [verification/testbench.sv]
module testbench
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		spc_insn_t insn;
		logic [7:0] lat_min;
		logic [7:0] lat_max;
		logic exc;
	} spc_row_t;
	logic CLK = 1'b0, SYS_RST = 1'b1, br_cond_ready = 1'b0, br_taken = 1'b0;
	logic br_predict = 1'b0, br_ctr = 1'b0, br_link = 1'b0, cr_resolve = 1'b0;
	logic cr_outcome = 1'b0, redirect, exc_taken, saw_redir, saw_flush;
	logic [1:0] fetch_valid, fetch_ready, retire_count;
	logic [2:0] branch_issued;
	logic [7:0] exc_code;
	logic [31:0] br_value = 32'h0000_0000;
	logic [31:0] count_reg, link_reg;
	logic [63:0] float_result;
	spc_insn_t insn0, insn1;
	logic [1:0] nf_valid, nf_ready, nf_retire;
	logic nf_exc;
	logic [7:0] nf_code, nf_seen;
	spc_insn_t nf_insn0, nf_insn1;
	int miscompares = 0, cmp_count = 0, lat, total, peak;
	function automatic spc_insn_t mk(spc_unit_t u, spc_op_t o, logic f, logic e);
		mk = '{u, o, f, 5'h01, 5'h02, 5'h03, e};
	endfunction
	spc_row_t rows [6] = '{
		'{mk(U_INT, OP_ALU, 1'b0, 1'b0), 8'h02, 8'h04, 1'b0},
		'{mk(U_SYS, OP_CMP, 1'b0, 1'b0), 8'h02, 8'h04, 1'b0},
		'{mk(U_LS, OP_MOV, 1'b0, 1'b0), 8'h02, 8'h06, 1'b0},
		'{mk(U_FLT, OP_ALU, 1'b1, 1'b0), 8'h02, 8'h08, 1'b0},
		'{mk(U_INT, OP_DIV, 1'b0, 1'b0), 8'h13, 8'h1a, 1'b0},
		'{mk(U_INT, OP_ALU, 1'b0, 1'b1), 8'h00, 8'h00, 1'b1}};
	initial forever #25 CLK = ~CLK;
	spc_fetch_model fetch_u (.clk(CLK), .rst(SYS_RST), .ready(fetch_ready),
		.valid(fetch_valid), .insn0(insn0), .insn1(insn1));
	spc_pipeline #(.HAS_FLOAT(1'b1)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST),
		.FETCH_VALID(fetch_valid), .FETCH_INSN0(insn0), .FETCH_INSN1(insn1),
		.FETCH_READY(fetch_ready), .REDIRECT(redirect), .BR_COND_READY(br_cond_ready),
		.BR_TAKEN(br_taken), .BR_PREDICT(br_predict), .BR_WRITES_CTR(br_ctr),
		.BR_WRITES_LINK(br_link), .BR_SPR_VALUE(br_value), .CR_RESOLVE(cr_resolve),
		.CR_OUTCOME(cr_outcome), .RETIRE_COUNT(retire_count), .EXC_TAKEN(exc_taken),
		.EXC_CODE(exc_code), .BRANCH_ISSUED(branch_issued), .COUNT_REG(count_reg),
		.LINK_REG(link_reg), .FLOAT_RESULT(float_result));
	// four-unit variant: a float op in dispatch slot 1 must trap
	spc_fetch_model nf_fetch_u (.clk(CLK), .rst(SYS_RST), .ready(nf_ready),
		.valid(nf_valid), .insn0(nf_insn0), .insn1(nf_insn1));
	spc_pipeline #(.HAS_FLOAT(1'b0)) dut_nf_u (.CLK(CLK), .SYS_RST(SYS_RST),
		.FETCH_VALID(nf_valid), .FETCH_INSN0(nf_insn0), .FETCH_INSN1(nf_insn1),
		.FETCH_READY(nf_ready), .REDIRECT(), .BR_COND_READY(br_cond_ready),
		.BR_TAKEN(br_taken), .BR_PREDICT(br_predict), .BR_WRITES_CTR(br_ctr),
		.BR_WRITES_LINK(br_link), .BR_SPR_VALUE(br_value), .CR_RESOLVE(cr_resolve),
		.CR_OUTCOME(cr_outcome), .RETIRE_COUNT(nf_retire), .EXC_TAKEN(nf_exc),
		.EXC_CODE(nf_code), .BRANCH_ISSUED(), .COUNT_REG(), .LINK_REG(),
		.FLOAT_RESULT());
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic do_reset();
		@(negedge CLK);
		SYS_RST = 1'b1;
		repeat (16) @(negedge CLK);
		SYS_RST = 1'b0;
		@(negedge CLK);
		check({30'h0, fetch_ready}, 32'h3);
		check({27'h0, branch_issued, retire_count}, 32'h0);
		check(float_result[63:32] | float_result[31:0], 32'h0);
		check({24'h0, exc_code}, {24'h0, EXC_NONE});
	endtask
	// pulses a branch straight to the branch unit, as the fetcher folds it
	task automatic branch(input logic rdy, input logic prd, input logic c, input logic l,
		input logic [31:0] v);
		{br_cond_ready, br_predict, br_ctr, br_link, br_value} = {rdy, prd, c, l, v};
		br_taken = 1'b1;
		@(negedge CLK);
		br_taken = 1'b0;
	endtask
	task automatic resolve_watch(input logic o);
		{cr_resolve, cr_outcome} = {1'b1, o};
		{saw_redir, saw_flush} = 2'b00;
		repeat (6) begin
			@(negedge CLK);
			cr_resolve = 1'b0;
			saw_redir |= (redirect === 1'b1);
			saw_flush |= (branch_issued[2] === 1'b1);
		end
	endtask
	// counts retirements until n seen or limit cycles pass
	task automatic drain(input int n, input int limit);
		{total, peak, lat} = 96'h0;
		while (total < n && lat < limit) begin
			@(negedge CLK);
			lat++;
			total += retire_count;
			if (retire_count > peak)
				peak = retire_count;
			if (fetch_ready === 2'h0)
				saw_flush = 1'b1;
		end
	endtask
	task automatic run_row(input spc_row_t r);
		logic got_exc;
		got_exc = 1'b0;
		fetch_u.pend_q.push_back(r.insn);
		lat = 0;
		while (fetch_u.pend_q.size() != 0 && lat < 50) begin
			@(negedge CLK);
			lat++;
		end
		lat = 0;
		while (retire_count === 2'h0 && lat < 40) begin
			got_exc |= (exc_taken === 1'b1);
			@(negedge CLK);
			lat++;
		end
		if (r.exc) begin
			check({31'h0, got_exc}, 32'h1);
			check(lat, 32'd40);
		end else
			check((lat >= r.lat_min && lat <= r.lat_max) ? 32'h1 : lat, 32'h1);
	endtask
	initial begin
		#(50 * 8000);
		miscompares++;
		complete_run();
	end
	initial begin
		do_reset();
		foreach (rows[i])
			run_row(rows[i]);
		do_reset();
		fetch_u.pend_q.push_back(mk(U_INT, OP_ALU, 1'b0, 1'b0));
		fetch_u.pend_q.push_back(mk(U_SYS, OP_ALU, 1'b0, 1'b0));
		drain(2, 30);
		check(peak, 32'h2);
		saw_flush = 1'b0;
		repeat (9) fetch_u.pend_q.push_back(mk(U_INT, OP_DIV, 1'b0, 1'b0));
		drain(9, 600);
		check(total, 32'd9);
		check({31'h0, saw_flush}, 32'h1);
		check(lat >= 9 * 19 ? 32'h1 : lat, 32'h1);
		branch(1'b1, 1'b0, 1'b0, 1'b1, 32'h1234_5678);
		repeat (3) @(negedge CLK);
		check(link_reg, 32'h1234_5678);
		branch(1'b1, 1'b0, 1'b1, 1'b0, 32'h0bad_f00d);
		repeat (3) @(negedge CLK);
		check(count_reg, 32'h0bad_f00d);
		branch(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
		resolve_watch(1'b1);
		check({30'h0, saw_redir, saw_flush}, 32'h0);
		branch(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
		resolve_watch(1'b0);
		check({30'h0, saw_redir, saw_flush}, 32'h3);
		// integer op retires, the float op behind it in slot 1 traps
		nf_fetch_u.pend_q.push_back(mk(U_INT, OP_ALU, 1'b0, 1'b0));
		nf_fetch_u.pend_q.push_back(mk(U_FLT, OP_ALU, 1'b1, 1'b0));
		total = 0;
		nf_seen = EXC_NONE;
		repeat (12) begin
			@(negedge CLK);
			total += nf_retire;
			if (nf_exc === 1'b1)
				nf_seen = nf_code;
		end
		check(total, 32'd1);
		check({24'h0, nf_seen}, {24'h0, EXC_FP_UNAVAIL});
		complete_run();
	end
endmodule
